// >>> hdl/adcs_pkg.sv
// Constants, field positions and types shared by the converter control block
package adcs_pkg;
  localparam int unsigned ADCS_AW = 8;
  localparam int unsigned ADCS_RES_W = 12;
  localparam int unsigned ADCS_IRQ_W = 2;
  localparam int unsigned ADCS_CONV_CLOCKS_DFLT = 16;

  localparam logic [7:0] ADCS_OFS_RES_LO = 8'h00;
  localparam logic [7:0] ADCS_OFS_RES_HI = 8'h04;
  localparam logic [7:0] ADCS_OFS_CTRL0 = 8'h08;
  localparam logic [7:0] ADCS_OFS_CTRL1 = 8'h0C;
  localparam logic [7:0] ADCS_OFS_CTRL2 = 8'h10;
  localparam logic [7:0] ADCS_OFS_BGAP = 8'h14;
  localparam logic [7:0] ADCS_OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADCS_OFS_IRQ_EN = 8'h1C;
  localparam logic [7:0] ADCS_OFS_IRQ_CLR = 8'h20;

  localparam logic [7:0] ADCS_RST_CTRL0 = 8'h00;
  localparam logic [7:0] ADCS_RST_CTRL1 = 8'h00;
  localparam logic [7:0] ADCS_RST_CTRL2 = 8'h00;
  localparam logic [7:0] ADCS_RST_BGAP = 8'h00;
  localparam logic [11:0] ADCS_RST_RESULT = 12'h000;

  localparam int unsigned ADCS_C0_START = 7;
  localparam int unsigned ADCS_C0_BUSY = 6;
  localparam int unsigned ADCS_C0_EN = 5;
  localparam int unsigned ADCS_C0_ALIGN = 4;
  localparam int unsigned ADCS_C1_SRC_LSB = 4;
  localparam int unsigned ADCS_C1_CKDIV_LSB = 0;
  localparam int unsigned ADCS_C2_AMP_EN = 7;
  localparam int unsigned ADCS_C2_PGA_IN = 4;
  localparam int unsigned ADCS_C2_REF_LSB = 2;
  localparam int unsigned ADCS_C2_GAIN_LSB = 0;
  localparam logic [7:0] ADCS_C2_MASK = 8'h9F;
  localparam int unsigned ADCS_BG_ON = 0;

  localparam int unsigned ADCS_IRQ_DONE = 0;
  localparam int unsigned ADCS_IRQ_REFUSED = 1;

  typedef enum logic [2:0] {
    ADCS_INT_NONE, ADCS_INT_SUPPLY, ADCS_INT_HALF_SUPPLY, ADCS_INT_QUARTER_SUPPLY,
    ADCS_INT_AMP, ADCS_INT_HALF_AMP, ADCS_INT_QUARTER_AMP
  } adcs_int_sel_t;

  typedef enum logic {ADCS_IDLE, ADCS_CONV} adcs_state_t;
endpackage

// >>> hdl/adcs_top.sv
// Converter sequencing, result formatting, input routing and APB register file
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
module adcs_top
  import adcs_pkg::*;
#(
  parameter int unsigned CONV_CLOCKS = ADCS_CONV_CLOCKS_DFLT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADCS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ADCS_RES_W-1:0] core_result,
  input wire logic [7:0] pin_analog_sel,
  output logic core_power_on,
  output logic core_start,
  output logic conv_busy,
  output logic ext_connect,
  output logic [2:0] ext_chan,
  output logic ext_float,
  output adcs_int_sel_t int_sel,
  output logic gnd_connect,
  output logic bandgap_on,
  output logic gain_amp_enable,
  output logic pga_input_sel,
  output logic [1:0] ref_select,
  output logic [1:0] pga_gain,
  output logic [7:0] pin_func_off,
  output logic [7:0] pin_pullup_off,
  output logic irq
);
  localparam int unsigned CW = $clog2(CONV_CLOCKS + 1);
  localparam logic [CW-1:0] LAST_CLK = CW'(CONV_CLOCKS - 1);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic start;
    logic en;
    logic align;
    logic [3:0] chan;
    logic [3:0] src;
    logic [2:0] ckdiv;
    logic [7:0] ctrl2;
    logic bg;
    logic [ADCS_RES_W-1:0] result;
    adcs_state_t state;
    logic busy;
    logic [6:0] presc;
    logic [CW-1:0] cnt;
    logic core_start;
    logic [ADCS_IRQ_W-1:0] irq_st;
    logic [ADCS_IRQ_W-1:0] irq_en;
    logic irq;
    logic ext_connect;
    logic [2:0] ext_chan;
    logic ext_float;
    adcs_int_sel_t int_sel;
    logic gnd_connect;
    logic [7:0] pin_func_off;
    logic [7:0] pin_pullup_off;
  } adcs_state_s_t;

  adcs_state_s_t s;
  adcs_state_s_t next_s;

  // Terminal value of the prescaler for a divider code
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  function automatic logic is_mapped(input logic [ADCS_AW-1:0] a);
    is_mapped = (a == ADCS_OFS_RES_LO) || (a == ADCS_OFS_RES_HI) ||
                (a == ADCS_OFS_CTRL0) || (a == ADCS_OFS_CTRL1) ||
                (a == ADCS_OFS_CTRL2) || (a == ADCS_OFS_BGAP) ||
                (a == ADCS_OFS_IRQ_STAT) || (a == ADCS_OFS_IRQ_EN) ||
                (a == ADCS_OFS_IRQ_CLR);
  endfunction

  function automatic logic is_external(input logic [3:0] src);
    is_external = (src == 4'h0) || (src == 4'h4) || (src[3:2] == 2'b11);
  endfunction

  logic access_phase;
  logic wr_commit;
  logic start_fall;
  logic tick;
  logic [7:0] rd_byte;
  logic [ADCS_IRQ_W-1:0] irq_set;
  logic [ADCS_IRQ_W-1:0] irq_clr;

  always_comb begin
    next_s = s;
    access_phase = psel && penable && !s.pready;
    wr_commit = psel && penable && s.pready && pwrite;
    start_fall = 1'b0;
    irq_set = '0;
    irq_clr = '0;
    rd_byte = 8'h00;
    tick = (s.presc == div_mask(s.ckdiv));

    // Read data is formed from current state and held until the next access
    unique case (paddr)
      ADCS_OFS_RES_LO: rd_byte = s.align ? s.result[7:0] : {s.result[3:0], 4'h0};
      ADCS_OFS_RES_HI: rd_byte = s.align ? {4'h0, s.result[11:8]} : s.result[11:4];
      ADCS_OFS_CTRL0: rd_byte = {s.start, s.busy, s.en, s.align, s.chan};
      ADCS_OFS_CTRL1: rd_byte = {s.src, 1'b0, s.ckdiv};
      ADCS_OFS_CTRL2: rd_byte = s.ctrl2;
      ADCS_OFS_BGAP: rd_byte = {7'h00, s.bg};
      ADCS_OFS_IRQ_STAT: rd_byte = 8'(s.irq_st);
      ADCS_OFS_IRQ_EN: rd_byte = 8'(s.irq_en);
      default: rd_byte = 8'h00;
    endcase

    // One wait state: pready rises the cycle after the access phase begins
    next_s.pready = access_phase;
    next_s.pslverr = access_phase && !is_mapped(paddr);
    if (access_phase) begin
      next_s.prdata = {24'h00_0000, rd_byte};
    end

    if (wr_commit) begin
      unique case (paddr)
        ADCS_OFS_CTRL0: begin
          // Busy position is read-only, the written bit is dropped
          next_s.start = pwdata[ADCS_C0_START];
          next_s.en = pwdata[ADCS_C0_EN];
          next_s.align = pwdata[ADCS_C0_ALIGN];
          next_s.chan = pwdata[3:0];
          start_fall = s.start && !pwdata[ADCS_C0_START];
        end
        ADCS_OFS_CTRL1: begin
          next_s.src = pwdata[ADCS_C1_SRC_LSB +: 4];
          next_s.ckdiv = pwdata[ADCS_C1_CKDIV_LSB +: 3];
        end
        ADCS_OFS_CTRL2: next_s.ctrl2 = pwdata[7:0] & ADCS_C2_MASK;
        ADCS_OFS_BGAP: next_s.bg = pwdata[ADCS_BG_ON];
        ADCS_OFS_IRQ_EN: next_s.irq_en = pwdata[ADCS_IRQ_W-1:0];
        ADCS_OFS_IRQ_CLR: irq_clr = pwdata[ADCS_IRQ_W-1:0];
        default: ;
      endcase
    end

    // Converter sequencing
    next_s.core_start = 1'b0;
    unique case (s.state)
      ADCS_IDLE: begin
        if (start_fall && s.en && !s.busy) begin
          next_s.state = ADCS_CONV;
          next_s.busy = 1'b1;
          next_s.presc = 7'h00;
          next_s.cnt = '0;
          next_s.core_start = 1'b1;
        end
      end
      ADCS_CONV: begin
        next_s.presc = tick ? 7'h00 : s.presc + 7'h01;
        if (tick) begin
          if (s.cnt == LAST_CLK) begin
            next_s.result = core_result;
            next_s.busy = 1'b0;
            next_s.state = ADCS_IDLE;
            irq_set[ADCS_IRQ_DONE] = 1'b1;
          end else begin
            next_s.cnt = s.cnt + CW'(1);
          end
        end
      end
    endcase

    // A start while busy or disabled only raises the refused event
    if (start_fall && (!s.en || s.busy)) begin
      irq_set[ADCS_IRQ_REFUSED] = 1'b1;
    end

    // Disabling aborts a running conversion; results are left untouched
    if (!s.en) begin
      next_s.state = ADCS_IDLE;
      next_s.busy = 1'b0;
      next_s.result = s.result;
    end

    // Set wins over a clear in the same cycle
    next_s.irq_st = (s.irq_st & ~irq_clr) | irq_set;
    next_s.irq = |(next_s.irq_st & next_s.irq_en);

    // Analog input routing
    next_s.ext_connect = is_external(s.src) && !s.chan[3];
    next_s.ext_float = is_external(s.src) && s.chan[3];
    next_s.ext_chan = s.chan[2:0];
    next_s.gnd_connect = (s.src[3:2] == 2'b10);
    unique case (s.src)
      4'h1: next_s.int_sel = ADCS_INT_SUPPLY;
      4'h2: next_s.int_sel = ADCS_INT_HALF_SUPPLY;
      4'h3: next_s.int_sel = ADCS_INT_QUARTER_SUPPLY;
      4'h5: next_s.int_sel = ADCS_INT_AMP;
      4'h6: next_s.int_sel = ADCS_INT_HALF_AMP;
      4'h7: next_s.int_sel = ADCS_INT_QUARTER_AMP;
      default: next_s.int_sel = ADCS_INT_NONE;
    endcase
    next_s.pin_func_off = pin_analog_sel;
    next_s.pin_pullup_off = pin_analog_sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.start <= ADCS_RST_CTRL0[ADCS_C0_START];
      s.en <= ADCS_RST_CTRL0[ADCS_C0_EN];
      s.align <= ADCS_RST_CTRL0[ADCS_C0_ALIGN];
      s.chan <= ADCS_RST_CTRL0[3:0];
      s.src <= ADCS_RST_CTRL1[ADCS_C1_SRC_LSB +: 4];
      s.ckdiv <= ADCS_RST_CTRL1[ADCS_C1_CKDIV_LSB +: 3];
      s.ctrl2 <= ADCS_RST_CTRL2;
      s.bg <= ADCS_RST_BGAP[ADCS_BG_ON];
      s.result <= ADCS_RST_RESULT;
      s.state <= ADCS_IDLE;
      s.int_sel <= ADCS_INT_NONE;
      s.ext_connect <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign core_power_on = s.en;
  assign core_start = s.core_start;
  assign conv_busy = s.busy;
  assign ext_connect = s.ext_connect;
  assign ext_chan = s.ext_chan;
  assign ext_float = s.ext_float;
  assign int_sel = s.int_sel;
  assign gnd_connect = s.gnd_connect;
  assign bandgap_on = s.bg;
  assign gain_amp_enable = s.ctrl2[ADCS_C2_AMP_EN];
  assign pga_input_sel = s.ctrl2[ADCS_C2_PGA_IN];
  assign ref_select = s.ctrl2[ADCS_C2_REF_LSB +: 2];
  assign pga_gain = s.ctrl2[ADCS_C2_GAIN_LSB +: 2];
  assign pin_func_off = s.pin_func_off;
  assign pin_pullup_off = s.pin_pullup_off;
  assign irq = s.irq;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ctrl0_fall_wr;
  assign ctrl0_fall_wr = wr_commit && (paddr == ADCS_OFS_CTRL0) && s.start &&
                         !pwdata[ADCS_C0_START];

  property p_start_sets_busy;
    ctrl0_fall_wr && s.en && !s.busy |=> conv_busy && core_start ##1 !core_start;
  endproperty
  a_start_sets_busy: assert property (p_start_sets_busy) else $error("start did not set busy");

  property p_refused_start;
    ctrl0_fall_wr && (s.busy || !s.en) |=> s.irq_st[ADCS_IRQ_REFUSED] && !core_start;
  endproperty
  a_refused_start: assert property (p_refused_start) else $error("refused start mishandled");

  property p_result_on_done;
    s.busy && s.en ##1 !s.busy |-> s.result == $past(core_result);
  endproperty
  a_result_on_done: assert property (p_result_on_done) else $error("result not taken at done");

  property p_disabled_hold;
    !s.en |=> $stable(s.result) && !conv_busy;
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("result changed while off");

  property p_fmt_left;
    access_phase && !pwrite && (paddr == ADCS_OFS_RES_HI) && !s.align
      |=> prdata == {24'h00_0000, $past(s.result[11:4])};
  endproperty
  a_fmt_left: assert property (p_fmt_left) else $error("left aligned high byte wrong");

  property p_fmt_right;
    access_phase && !pwrite && (paddr == ADCS_OFS_RES_LO) && s.align
      |=> prdata == {24'h00_0000, $past(s.result[7:0])};
  endproperty
  a_fmt_right: assert property (p_fmt_right) else $error("right aligned low byte wrong");

  property p_unused_zero;
    access_phase && !pwrite && (paddr == ADCS_OFS_RES_LO) && !s.align
      |=> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h00_0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused result bits not zero");

  property p_route;
    ##1 ext_connect |-> is_external($past(s.src)) && !$past(s.chan[3]) &&
                        int_sel == ADCS_INT_NONE && !gnd_connect;
  endproperty
  a_route: assert property (p_route) else $error("external routing wrong");

  property p_ground;
    s.src[3:2] == 2'b10 |=> gnd_connect && !ext_connect && !ext_float;
  endproperty
  a_ground: assert property (p_ground) else $error("reserved source not grounded");

  property p_int_supply;
    s.src == 4'h1 |=> int_sel == ADCS_INT_SUPPLY && !ext_connect;
  endproperty
  a_int_supply: assert property (p_int_supply) else $error("supply source not selected");

  property p_pins;
    ##1 1'b1 |-> pin_pullup_off == $past(pin_analog_sel) && pin_func_off == $past(pin_analog_sel);
  endproperty
  a_pins: assert property (p_pins) else $error("pin override wrong");

  property p_div_one;
    s.state == ADCS_CONV && s.ckdiv == 3'h0 && s.cnt != LAST_CLK && s.en
      |=> s.cnt == $past(s.cnt) + CW'(1);
  endproperty
  a_div_one: assert property (p_div_one) else $error("undivided clock missed a tick");

  property p_bandgap;
    wr_commit && paddr == ADCS_OFS_BGAP |=> bandgap_on == $past(pwdata[ADCS_BG_ON]);
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap control not applied");

  c_conv_done: cover property (conv_busy ##1 !conv_busy && s.irq_st[ADCS_IRQ_DONE]);
  c_refused: cover property (ctrl0_fall_wr && s.busy);
  c_irq: cover property (irq);
  c_slow_div: cover property (conv_busy && s.ckdiv == 3'h7);
endmodule

// >>> verification/adcs_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((exp) !== (got)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module adcs_top_tb
  import adcs_pkg::*;
;
  // Short conversions keep the divider sweep fast
  localparam int CC = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADCS_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [ADCS_RES_W-1:0] core_result = '0;
  logic [7:0] pin_analog_sel = '0;
  logic core_power_on, core_start, conv_busy, ext_connect, ext_float, gnd_connect;
  logic bandgap_on, gain_amp_enable, pga_input_sel, irq;
  logic [2:0] ext_chan;
  adcs_int_sel_t int_sel;
  logic [1:0] ref_select, pga_gain;
  logic [7:0] pin_func_off, pin_pullup_off;
  logic [31:0] rdata, seed = 32'h0000_baf9;
  logic serr;
  int num_errors = 0;
  int n_tests = 0;
  int busy_cnt = 0;
  int start_cnt = 0;

  adcs_top #(.CONV_CLOCKS(CC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_result(core_result),
    .pin_analog_sel(pin_analog_sel), .core_power_on(core_power_on), .core_start(core_start),
    .conv_busy(conv_busy), .ext_connect(ext_connect), .ext_chan(ext_chan),
    .ext_float(ext_float), .int_sel(int_sel), .gnd_connect(gnd_connect),
    .bandgap_on(bandgap_on), .gain_amp_enable(gain_amp_enable),
    .pga_input_sel(pga_input_sel), .ref_select(ref_select), .pga_gain(pga_gain),
    .pin_func_off(pin_func_off), .pin_pullup_off(pin_pullup_off), .irq(irq));

  always #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (conv_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (core_start === 1'b1) start_cnt <= start_cnt + 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Returns {high byte, low byte} for a given alignment
  function automatic logic [15:0] fmt(input logic [11:0] r, input logic al);
    return al ? {4'h0, r} : {r, 4'h0};
  endfunction

  function automatic adcs_int_sel_t isel(input logic [3:0] s);
    case (s)
      4'h1: return ADCS_INT_SUPPLY;
      4'h2: return ADCS_INT_HALF_SUPPLY;
      4'h3: return ADCS_INT_QUARTER_SUPPLY;
      4'h5: return ADCS_INT_AMP;
      4'h6: return ADCS_INT_HALF_AMP;
      4'h7: return ADCS_INT_QUARTER_AMP;
      default: return ADCS_INT_NONE;
    endcase
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) `CHK("pready", 1'b1, pready)
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic chk_res(input logic [11:0] r, input logic [7:0] c0);
    logic [15:0] e;
    e = fmt(r, c0[ADCS_C0_ALIGN]);
    wr(ADCS_OFS_CTRL0, c0);
    rd(ADCS_OFS_RES_LO);
    `CHK("result_low_byte", {24'h00_0000, e[7:0]}, rdata)
    rd(ADCS_OFS_RES_HI);
    `CHK("result_high_byte", {24'h00_0000, e[15:8]}, rdata)
  endtask

  task automatic conv(input logic [2:0] dv, input logic [11:0] r, input logic refuse);
    int n, b0, s0;
    n = 0;
    core_result <= r;
    wr(ADCS_OFS_CTRL1, {5'h00, dv});
    wr(ADCS_OFS_CTRL0, 8'h20);
    wr(ADCS_OFS_CTRL0, 8'hA0);
    b0 = busy_cnt;
    s0 = start_cnt;
    wr(ADCS_OFS_CTRL0, 8'h20);
    `CHK("conv_busy", 1'b1, conv_busy)
    rd(ADCS_OFS_CTRL0);
    // A short undivided conversion is over before the read samples the flag
    `CHK("busy_flag", ((CC << dv) > 2) ? 8'h60 : 8'h20, rdata[7:0])
    // A second start sequence while busy must be refused
    if (refuse) begin
      wr(ADCS_OFS_CTRL0, 8'hA0);
      wr(ADCS_OFS_CTRL0, 8'h20);
    end
    while (conv_busy !== 1'b0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    `CHK("busy_length", CC << dv, busy_cnt - b0)
    `CHK("start_pulses", 1, start_cnt - s0)
    @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    num_errors++;
    $display("ERROR watchdog expected finish seen hang");
    end_of_test();
  end

  initial begin
    logic [3:0] ch;
    logic ext;
    logic [11:0] r;
    logic [11:0] last;
    logic [7:0] p;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      `CHK("reset_value", 32'h0000_0000, rdata)
      `CHK("mapped_err", 1'b0, serr)
    end
    rd(8'h40);
    `CHK("unmapped_err", 1'b1, serr)
    `CHK("unmapped_data", 32'h0000_0000, rdata)
    wr(ADCS_OFS_CTRL0, 8'h7F);
    rd(ADCS_OFS_CTRL0);
    `CHK("ctrl0_busy_ignored", 8'h3F, rdata[7:0])
    wr(ADCS_OFS_CTRL2, 8'hFF);
    rd(ADCS_OFS_CTRL2);
    `CHK("ctrl2", {ADCS_C2_MASK, 1'b1, 1'b1, 2'b11, 2'b11}, {rdata[7:0], gain_amp_enable,
      pga_input_sel, ref_select, pga_gain})
    wr(ADCS_OFS_BGAP, 8'hFF);
    `CHK("bandgap_on", 1'b1, bandgap_on)
    wr(ADCS_OFS_BGAP, 8'h00);
    `CHK("bandgap_off", 1'b0, bandgap_on)
    $display("test registers done");
    for (int s = 0; s < 16; s++) begin
      seed = lfsr(seed);
      ch = (s == 0) ? 4'h7 : (s == 4) ? 4'h8 : seed[3:0];
      ext = (s == 0) || (s == 4) || (s[3:2] == 2'b11);
      wr(ADCS_OFS_CTRL1, {s[3:0], 4'hF});
      wr(ADCS_OFS_CTRL0, {4'h0, ch});
      rd(ADCS_OFS_CTRL1);
      `CHK("ctrl1", {s[3:0], 4'h7}, rdata[7:0])
      `CHK("ext_connect", ext && !ch[3], ext_connect)
      `CHK("ext_float", ext && ch[3], ext_float)
      if (ext && !ch[3]) `CHK("ext_chan", ch[2:0], ext_chan)
      `CHK("int_sel", isel(s[3:0]), int_sel)
      `CHK("gnd_connect", s[3:2] == 2'b10, gnd_connect)
    end
    $display("test routing done");
    repeat (4) begin
      seed = lfsr(seed);
      p = seed[7:0];
      pin_analog_sel <= p;
      repeat (2) @(posedge pclk);
      `CHK("pin_func_off", p, pin_func_off)
      `CHK("pin_pullup_off", p, pin_pullup_off)
    end
    $display("test pins done");
    wr(ADCS_OFS_IRQ_EN, 8'h03);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      r = (i == 0) ? 12'hFFF : (i == 1) ? 12'h001 : seed[11:0];
      if (i == 4) wr(ADCS_OFS_IRQ_EN, 8'h00);
      conv(i[2:0], r, i == 3);
      `CHK("irq_level", i < 4, irq)
      `CHK("power_on", 1'b1, core_power_on)
      rd(ADCS_OFS_IRQ_STAT);
      `CHK("irq_status", {i == 3, 1'b1}, rdata[1:0])
      wr(ADCS_OFS_IRQ_CLR, 8'h03);
      @(posedge pclk);
      `CHK("irq_cleared", 1'b0, irq)
      chk_res(r, 8'h20);
      chk_res(r, 8'h30);
      last = r;
    end
    $display("test conversions done");
    wr(ADCS_OFS_CTRL1, 8'h07);
    wr(ADCS_OFS_CTRL0, 8'h20);
    wr(ADCS_OFS_CTRL0, 8'hA0);
    core_result <= ~last;
    wr(ADCS_OFS_CTRL0, 8'h20);
    wr(ADCS_OFS_CTRL0, 8'h00);
    @(posedge pclk);
    `CHK("abort_busy", 1'b0, conv_busy)
    `CHK("power_off", 1'b0, core_power_on)
    chk_res(last, 8'h00);
    chk_res(last, 8'h10);
    wr(ADCS_OFS_CTRL0, 8'h80);
    wr(ADCS_OFS_CTRL0, 8'h00);
    `CHK("disabled_start", 1'b0, conv_busy)
    rd(ADCS_OFS_IRQ_STAT);
    `CHK("refused_flag", 1'b1, rdata[ADCS_IRQ_REFUSED])
    $display("test abort done");
    end_of_test();
  end
endmodule
